// [pci_target_config_preload.v]
// PCI target config space with post-reset EEPROM preload and retry.
// Assumes PCI signals sampled synchronous to mclk; tristate resolved outside.
`timescale 1ns/1ps
`include "cfg_regs.vh"
// Behaviour
// - Byte enables select written bytes only
// - 32-bit data, up to 33 MHz
// - Fast back-to-back accepted, no turnaround idle
// - Data parity fault drives PERR#
// - Address parity fault: transaction unclaimed
// - Target reaches only registers and config
// - Payload moved by master under arbiter
// - Unimplemented config reads zero, writes ignored
// - Preload from EEPROM at address 1010000
// - Preload takes about 1 ms
// - Accesses during preload get retry
// - Subsystem IDs loaded, default zero
// - Max_Lat/Min_Gnt loaded, default 26H/0FH
// - BAR bits 31..9 writable, rest zero
module pci_target_config_preload #(
    parameter LOAD_CYC = 10000
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        frame_n,
    input  wire        irdy_n,
    input  wire        idsel,
    input  wire [31:0] ad_in,
    input  wire [3:0]  cbe_n,
    input  wire        par_in,
    input  wire        scl_in,
    input  wire        sda_in,
    input  wire [31:0] reg_rdata,
    output reg  [31:0] ad_out,
    output reg         ad_oe_n,
    output reg         par_out,
    output reg         par_oe_n,
    output reg         devsel_n,
    output reg         trdy_n,
    output reg         stop_n,
    output reg         tctl_oe_n,
    output reg         perr_n,
    output reg         perr_oe_n,
    output reg         scl_oe_n,
    output reg         sda_oe_n,
    output reg         reg_wr,
    output reg         reg_rd,
    output reg  [8:0]  reg_addr,
    output reg  [31:0] reg_wdata,
    output reg  [3:0]  reg_be,
    output reg         master_en,
    output reg         fb2b_en,
    output reg  [7:0]  latency,
    output reg         loading
);
    localparam [4:0] T_IDLE = 5'h01, T_DATA = 5'h02, T_RETRY = 5'h04,
                     T_TURN = 5'h08, T_WAIT = 5'h10;
    reg [4:0]  st_r;
    reg [15:0] cmd_r;
    reg [15:0] stat_r;
    reg [31:9] bar_r;
    reg [7:0]  intline_r;
    reg [31:0] subsys_r;
    reg [7:0]  maxlat_r;
    reg [7:0]  mingnt_r;
    reg        is_cfg_r;
    reg        is_wr_r;
    reg [5:0]  off_r;
    reg [19:0] wait_r;
    reg        chk_r;
    reg [35:0] prev_r;
    reg        ee_taken_r;
    reg        frame_d_r;
    wire       ee_scl_oe_n;
    wire       ee_sda_oe_n;
    wire [47:0] ee_data;
    wire       ee_ok;
    wire       ee_done;
    wire       par_calc;
    wire       prev_par;
    // Host presents a new address when FRAME# falls or re-asserts at once
    wire       addr_phase = !frame_n && (frame_d_r || st_r == T_IDLE);
    wire [3:0] cmd = cbe_n;
    wire       cfg_hit = idsel && ad_in[1:0] == 2'b00 &&
                         (cmd == `PCI_CMD_CFGRD || cmd == `PCI_CMD_CFGWR);
    wire       mem_hit = cmd_r[`CMD_MEM_BIT] && ad_in[31:9] == bar_r &&
                         (cmd == `PCI_CMD_MEMRD || cmd == `PCI_CMD_MEMWR);
    reg  [31:0] cfg_rd;

    ee_loader u_ee (
        .mclk     (mclk),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .scl_oe_n (ee_scl_oe_n),
        .sda_oe_n (ee_sda_oe_n),
        .data     (ee_data),
        .ok       (ee_ok),
        .done     (ee_done)
    );

    parity_unit u_par_now (
        .ad    (ad_in),
        .cbe_n (cbe_n),
        .par   (par_calc)
    );

    parity_unit u_par_prev (
        .ad    (prev_r[35:4]),
        .cbe_n (prev_r[3:0]),
        .par   (prev_par)
    );

    // Config read mux; anything not listed reads zero
    always @* begin
        case (off_r)
        `CFG_ID_OFF:      cfg_rd = 32'h0; // identity parameters unused here
        `CFG_STATCMD_OFF: cfg_rd = {stat_r, cmd_r};
        `CFG_CLASS_OFF:   cfg_rd = `CFG_CLASSREV;
        `CFG_LAT_OFF:     cfg_rd = {16'h0000, latency, 8'h00};
        `CFG_BAR_OFF:     cfg_rd = {bar_r, 9'h000};
        `CFG_SUBSYS_OFF:  cfg_rd = subsys_r;
        `CFG_INTR_OFF:    cfg_rd = {maxlat_r, mingnt_r, `CFG_INTPIN, intline_r};
        default:          cfg_rd = 32'h0;
        endcase
    end

    // Preload timing window and EEPROM result capture
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_r     <= 20'h00000;
            loading    <= 1'b1;
            ee_taken_r <= 1'b0;
            subsys_r   <= `CFG_SUBSYS_RST;
            maxlat_r   <= `CFG_MAXLAT_RST;
            mingnt_r   <= `CFG_MINGNT_RST;
            scl_oe_n   <= 1'b1;
            sda_oe_n   <= 1'b1;
        end else begin
            scl_oe_n <= ee_scl_oe_n;
            sda_oe_n <= ee_sda_oe_n;
            if (wait_r != LOAD_CYC[19:0])
                wait_r <= wait_r + 20'h00001;
            if (ee_done && !ee_taken_r) begin
                ee_taken_r <= 1'b1;
                if (ee_ok) begin
                    subsys_r <= ee_data[47:16];
                    maxlat_r <= ee_data[15:8];
                    mingnt_r <= ee_data[7:0];
                end
            end
            // Done when EEPROM finished and minimum window elapsed
            if (ee_taken_r && wait_r == LOAD_CYC[19:0])
                loading <= 1'b0;
        end
    end

    // Target state machine
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= T_IDLE; frame_d_r <= 1'b1; is_cfg_r <= 1'b0; is_wr_r <= 1'b0;
            off_r <= 6'h00; cmd_r <= 16'h0000; stat_r <= `CFG_STAT_FIXED;
            bar_r <= 23'h0; intline_r <= 8'h00; latency <= 8'h00;
            ad_out <= 32'h0; ad_oe_n <= 1'b1; devsel_n <= 1'b1; trdy_n <= 1'b1;
            stop_n <= 1'b1; tctl_oe_n <= 1'b1; reg_wr <= 1'b0; reg_rd <= 1'b0;
            reg_addr <= 9'h000; reg_wdata <= 32'h0; reg_be <= 4'h0;
            master_en <= 1'b0; fb2b_en <= 1'b0;
        end else begin
            frame_d_r <= frame_n;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            master_en <= cmd_r[`CMD_MASTER_BIT];
            fb2b_en <= cmd_r[`CMD_FB2B_BIT];
            case (st_r)
            T_IDLE, T_TURN: begin
                devsel_n <= 1'b1; trdy_n <= 1'b1; stop_n <= 1'b1;
                ad_oe_n <= 1'b1;
                tctl_oe_n <= (st_r == T_TURN) ? 1'b0 : 1'b1;
                st_r <= T_IDLE;
                // Address parity is checked a cycle late, so claim on next clock
                if (addr_phase && (cfg_hit || mem_hit)) begin
                    is_cfg_r <= cfg_hit;
                    is_wr_r  <= cmd[0];
                    // Offsets past 3CH map to an unused slot that reads zero
                    off_r    <= (ad_in[7:6] == 2'b00) ? {ad_in[5:2], 2'b00} : 6'h38;
                    reg_addr <= ad_in[8:0];
                    st_r     <= T_WAIT;
                end
            end
            T_WAIT: begin
                if (par_in != prev_par) begin
                    st_r <= T_IDLE;
                    if (cmd_r[`CMD_PERR_BIT]) stat_r[15] <= 1'b1;
                end else if (loading) begin
                    devsel_n <= 1'b0; stop_n <= 1'b0; tctl_oe_n <= 1'b0;
                    st_r <= T_RETRY;
                end else begin
                    devsel_n <= 1'b0; tctl_oe_n <= 1'b0;
                    st_r <= T_DATA;
                end
            end
            T_RETRY: begin
                if (frame_n) begin
                    devsel_n <= 1'b1; stop_n <= 1'b1; st_r <= T_TURN;
                end
            end
            T_DATA: begin
                if (!irdy_n && trdy_n) begin
                    trdy_n <= 1'b0; stop_n <= 1'b0;  // single phase, disconnect
                    if (is_wr_r) begin
                        if (is_cfg_r) begin
                            // Byte lanes gate each field independently
                            if (off_r == `CFG_STATCMD_OFF) begin
                                if (!cbe_n[0]) cmd_r[7:0] <= ad_in[7:0] & 8'h46;
                                if (!cbe_n[1]) cmd_r[15:8] <= ad_in[15:8] & 8'h02;
                                if (!cbe_n[3]) stat_r[15:8] <= stat_r[15:8] & ~(ad_in[31:24] & 8'h81);
                            end
                            if (off_r == `CFG_LAT_OFF && !cbe_n[1]) latency <= ad_in[15:8];
                            if (off_r == `CFG_BAR_OFF) begin
                                if (!cbe_n[1]) bar_r[15:9] <= ad_in[15:9];
                                if (!cbe_n[2]) bar_r[23:16] <= ad_in[23:16];
                                if (!cbe_n[3]) bar_r[31:24] <= ad_in[31:24];
                            end
                            if (off_r == `CFG_INTR_OFF && !cbe_n[0]) intline_r <= ad_in[7:0];
                        end else begin
                            reg_wr <= 1'b1; reg_wdata <= ad_in; reg_be <= ~cbe_n;
                        end
                    end else begin
                        ad_oe_n <= 1'b0;
                        ad_out <= is_cfg_r ? cfg_rd : reg_rdata;
                        reg_rd <= !is_cfg_r;
                        reg_be <= ~cbe_n;
                    end
                end else if (!trdy_n) begin
                    trdy_n <= 1'b1; ad_oe_n <= 1'b1;
                    if (frame_n) begin
                        devsel_n <= 1'b1; stop_n <= 1'b1; st_r <= T_TURN;
                    end
                end
            end
            default: st_r <= T_IDLE;
            endcase
            // Detected-parity flag; a set in the clearing cycle wins
            if (chk_r && par_in != prev_par) stat_r[15] <= 1'b1;
        end
    end

    // Parity: drive PAR for reads, check write data phases for PERR#
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_r <= 36'h0; chk_r <= 1'b0; par_out <= 1'b0; par_oe_n <= 1'b1;
            perr_n <= 1'b1; perr_oe_n <= 1'b1;
        end else begin
            prev_r   <= {ad_in, cbe_n};
            par_out  <= ^ad_out ^ ^cbe_n;
            par_oe_n <= ad_oe_n;
            chk_r    <= st_r == T_DATA && is_wr_r && !irdy_n && trdy_n;
            perr_oe_n <= !(chk_r || !perr_n);
            if (chk_r && par_in != prev_par && cmd_r[`CMD_PERR_BIT]) begin
                perr_n <= 1'b0;
            end else begin
                perr_n <= 1'b1;
            end
        end
    end
    // 32-bit datapath at 33 MHz; par_calc is unused, prev_par is the check term
    wire unused_par = par_calc;
endmodule

// [cfg_regs.vh]
// Constants of the PCI target front end with serial EEPROM preload.
// Assumes inclusion by bare name from the design files and the testbench.
`ifndef CFG_REGS_VH
`define CFG_REGS_VH
// Configuration dword offsets (byte addresses)
`define CFG_ID_OFF        6'h00
`define CFG_STATCMD_OFF   6'h04
`define CFG_CLASS_OFF     6'h08
`define CFG_LAT_OFF       6'h0C
`define CFG_BAR_OFF       6'h10
`define CFG_SUBSYS_OFF    6'h2C
`define CFG_INTR_OFF      6'h3C
// Fixed values and reset values
`define CFG_CLASSREV      32'h04800001
`define CFG_STAT_FIXED    16'h0280
`define CFG_INTPIN        8'h01
`define CFG_SUBSYS_RST    32'h00000000
`define CFG_MAXLAT_RST    8'h26
`define CFG_MINGNT_RST    8'h0F
// Field positions
`define CMD_MEM_BIT       1
`define CMD_MASTER_BIT    2
`define CMD_PERR_BIT      6
`define CMD_FB2B_BIT      9
`define BAR_LOW_BIT       9
// PCI commands
`define PCI_CMD_MEMRD     4'h6
`define PCI_CMD_MEMWR     4'h7
`define PCI_CMD_CFGRD     4'hA
`define PCI_CMD_CFGWR     4'hB
// EEPROM preload
`define EE_DEV_ADDR       7'h50
`define EE_NBYTES         4'h6
`define EE_LOAD_TIME_NS   1000000
`define MCLK_PERIOD_NS    100
`define I2C_HALF_NS       5000
`define I2C_HALF_CYC      ((`I2C_HALF_NS) / (`MCLK_PERIOD_NS))
`endif

// [parity_unit.v]
// Even parity over AD and C/BE# for PCI parity checking.
// Assumes inputs are synchronous to mclk.
`timescale 1ns/1ps
module parity_unit (
    input  wire [31:0] ad,
    input  wire [3:0]  cbe_n,
    output wire        par
);
    // Parity is XOR of all 36 bits
    assign par = ^{ad, cbe_n};
endmodule

// [ee_loader.v]
// I2C master that reads the preload bytes from the serial EEPROM.
// Assumes open-drain pins resolved outside; enable low means drive low.
`timescale 1ns/1ps
`include "cfg_regs.vh"
module ee_loader (
    input  wire        mclk,
    input  wire        rst,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         scl_oe_n,
    output reg         sda_oe_n,
    output reg  [47:0] data,
    output reg         ok,
    output reg         done
);
    localparam [3:0] S_START = 4'h1, S_BIT = 4'h2, S_STOP = 4'h4, S_END = 4'h8;
    localparam [15:0] HALF = `I2C_HALF_CYC;
    reg [3:0]  st_r;
    reg [15:0] tmr_r;
    reg [1:0]  ph_r;
    reg [3:0]  bit_r;
    reg [3:0]  byte_r;
    reg [8:0]  sh_r;
    reg        rd_r;
    // Phase 0..3 per bit: setup, SCL high, sample, SCL low
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= S_START; tmr_r <= 16'h0000; ph_r <= 2'h0; bit_r <= 4'h0;
            byte_r <= 4'h0; sh_r <= 9'h000; rd_r <= 1'b0; scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1; data <= 48'h0; ok <= 1'b0; done <= 1'b0;
        end else if (tmr_r != 16'h0000) begin
            tmr_r <= tmr_r - 16'h0001;
        end else begin
            tmr_r <= HALF;
            case (st_r)
            // Release SDA, then SCL, before the start edge, so a restart is seen
            S_START: begin
                ph_r <= ph_r + 2'h1;
                case (ph_r)
                2'h0: sda_oe_n <= 1'b1;
                2'h1: scl_oe_n <= 1'b1;
                2'h2: sda_oe_n <= 1'b0;
                default: begin
                    scl_oe_n <= 1'b0;
                    sh_r <= rd_r ? {`EE_DEV_ADDR, 1'b1, 1'b1} : {`EE_DEV_ADDR, 1'b0, 1'b1};
                    bit_r <= 4'h0;
                    st_r <= S_BIT;
                end
                endcase
            end
            S_BIT: begin
                ph_r <= ph_r + 2'h1;
                case (ph_r)
                2'h0: sda_oe_n <= sh_r[8];
                2'h1: scl_oe_n <= 1'b1;
                2'h2: begin
                    if (bit_r == 4'h8) begin
                        if (!rd_r || byte_r == 4'h0) begin
                            if (sda_in) st_r <= S_STOP;
                        end
                    end else if (rd_r && byte_r != 4'h0)
                        sh_r <= {sh_r[7:0], sda_in};
                end
                default: begin
                    scl_oe_n <= 1'b0;
                    if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        if (!rd_r) begin
                            // Dummy write of word address 0 then restart
                            if (byte_r == 4'h1) begin
                                rd_r <= 1'b1; byte_r <= 4'h0; st_r <= S_START;
                                sda_oe_n <= 1'b1; ph_r <= 2'h0;
                            end else begin
                                byte_r <= 4'h1; sh_r <= 9'h001;
                            end
                        end else begin
                            if (byte_r != 4'h0)
                                data <= {data[39:0], sh_r[7:0]};
                            if (byte_r == `EE_NBYTES) begin
                                ok <= 1'b1; st_r <= S_STOP;
                            end else begin
                                byte_r <= byte_r + 4'h1;
                                // ACK except after last byte
                                sh_r <= (byte_r == `EE_NBYTES - 4'h1) ? 9'h1FF : 9'h1FE;
                            end
                        end
                    end else begin
                        bit_r <= bit_r + 4'h1;
                        if (!(rd_r && byte_r != 4'h0)) sh_r <= {sh_r[7:0], 1'b1};
                    end
                end
                endcase
            end
            S_STOP: begin
                ph_r <= ph_r + 2'h1;
                if (ph_r == 2'h0) begin scl_oe_n <= 1'b0; sda_oe_n <= 1'b0; end
                if (ph_r == 2'h1) scl_oe_n <= 1'b1;
                if (ph_r == 2'h2) begin sda_oe_n <= 1'b1; st_r <= S_END; end
            end
            S_END: done <= 1'b1;
            default: st_r <= S_END;
            endcase
        end
    end
endmodule

// [ee_model.sv]
// Serial EEPROM model that answers every read byte with one fill value.
// Assumes open-drain lines resolved with pull-ups by the bench.
`timescale 1ns/1ps
module ee_model #(
    parameter [6:0] DEV  = 7'h50,
    parameter [7:0] FILL = 8'h5A
) (
    input  wire       scl,
    input  wire       sda,
    input  wire       ack_en,
    output reg        sda_n,
    output reg  [7:0] dev_byte
);
    reg [7:0] sh;
    reg [3:0] bitc;
    reg       act, rd, first;

    initial begin
        sda_n    = 1'b1;
        act      = 1'b0;
        dev_byte = 8'h00;
    end
    // Start condition restarts the byte framing
    always @(negedge sda) begin
        if (scl) begin
            act   = 1'b1;
            first = 1'b1;
            rd    = 1'b0;
            bitc  = 4'h0;
        end
    end
    // Sample on rising clock; a master nack ends a read
    always @(posedge scl) begin
        if (act) begin
            if (bitc < 4'h8)
                sh = {sh[6:0], sda};
            else if (rd && sda)
                act = 1'b0;
            bitc = bitc + 4'h1;
        end
    end
    // Drive only after the falling clock, so data never moves while it is high
    always @(negedge scl) begin
        sda_n = 1'b1;
        if (act) begin
            if (bitc == 4'h9)
                bitc = 4'h0;
            if (bitc == 4'h8 && !rd) begin
                if (first) begin
                    dev_byte = sh;
                    first    = 1'b0;
                    rd       = sh[0];
                    act      = ack_en && sh[7:1] == DEV;
                end
                sda_n = !act;
            end else if (rd && bitc < 4'h8)
                sda_n = FILL[4'h7 - bitc];
        end
    end
endmodule

// [pci_cfg_chk.sv]
// Port checker for the config target with EEPROM preload.
// Assumes one clock mclk and an asynchronous active-high rst.
`timescale 1ns/1ps
module pci_cfg_chk (
    input wire        mclk,
    input wire        rst,
    input wire        frame_n,
    input wire [31:0] ad_in,
    input wire [3:0]  cbe_n,
    input wire        par_in,
    input wire        devsel_n,
    input wire        trdy_n,
    input wire        stop_n,
    input wire        perr_n,
    input wire        perr_oe_n,
    input wire        scl_oe_n,
    input wire        sda_oe_n,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire        loading
);
    // Single domain, so clock and reset are given once
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);

    retry_load_a: assert property (loading |-> trdy_n)
        else $error("data accepted during preload");
    late_retry_a: assert property (!loading && !$past(loading, 4) && !stop_n |-> !trdy_n)
        else $error("retry after preload");
    // Bad address parity: no claim over the response window
    bad_apar_a: assert property ($fell(frame_n) ##1 par_in != ^{$past(ad_in), $past(cbe_n)}
        |-> devsel_n [*4]) else $error("claim despite address parity");
    term_claim_a: assert property (!trdy_n || !stop_n |-> !devsel_n)
        else $error("termination without claim");
    perr_drive_a: assert property (!perr_n |-> !perr_oe_n)
        else $error("parity flag not driven");
    load_start_a: assert property ($past(rst) |-> ##[0:2] loading)
        else $error("no preload after reset");
    ee_idle_a: assert property (!loading && !$past(loading) |-> scl_oe_n && sda_oe_n)
        else $error("serial lines held after preload");
    reg_gate_a: assert property (reg_wr || reg_rd |-> !loading)
        else $error("register access during preload");
    // Main scenarios reached
    cover property ($fell(loading));
    cover property (!stop_n && trdy_n);
    cover property (reg_rd);
    cover property (!perr_n);
endmodule

bind pci_target_config_preload pci_cfg_chk chk (
    .mclk(mclk), .rst(rst), .frame_n(frame_n), .ad_in(ad_in), .cbe_n(cbe_n),
    .par_in(par_in), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n),
    .perr_n(perr_n), .perr_oe_n(perr_oe_n), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .loading(loading)
);

// [testbench.sv]
// Self-checking bench for the config target with EEPROM preload.
// Assumes the EEPROM model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "cfg_regs.vh"
module testbench;
    reg         mclk, rst, frame_n, irdy_n, idsel, par_drv, ack_en;
    reg  [31:0] ad_drv, reg_rdata, got;
    reg  [3:0]  cbe_n;
    reg  [1:0]  how;
    reg         pe;
    integer     n_errors, comparisons, cycles;
    wire [31:0] ad_in, ad_out, reg_wdata;
    wire [8:0]  reg_addr;
    wire [7:0]  latency, dev_byte;
    wire [3:0]  reg_be;
    wire        ad_oe_n, par_out, par_oe_n, devsel_n, trdy_n, stop_n, tctl_oe_n, perr_n;
    wire        perr_oe_n, scl_oe_n, sda_oe_n, reg_wr, reg_rd, master_en, fb2b_en;
    wire        loading, ee_sda_n, par_in, sda;

    // Target drive wins on shared lines; the data line idles high by pull-up
    assign ad_in  = ad_oe_n ? ad_drv : ad_out;
    assign par_in = par_oe_n ? par_drv : par_out;
    assign sda    = sda_oe_n & ee_sda_n;

    pci_target_config_preload #(.LOAD_CYC(50)) uut (
        .mclk(mclk), .rst(rst), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel),
        .ad_in(ad_in), .cbe_n(cbe_n), .par_in(par_in), .scl_in(scl_oe_n), .sda_in(sda),
        .reg_rdata(reg_rdata), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .par_out(par_out),
        .par_oe_n(par_oe_n), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n),
        .tctl_oe_n(tctl_oe_n), .perr_n(perr_n), .perr_oe_n(perr_oe_n),
        .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
        .master_en(master_en), .fb2b_en(fb2b_en), .latency(latency), .loading(loading)
    );
    ee_model ee (.scl(scl_oe_n), .sda(sda), .ack_en(ack_en), .sda_n(ee_sda_n),
        .dev_byte(dev_byte));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Sticky capture of the one-cycle parity flag pulse
    always @(negedge mclk)
        if (perr_n === 1'b0) pe = 1'b1;
    // Ceiling covers two preloads plus the accesses
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end

    task check(input [31:0] g, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                $display("ERROR at %0t: got %h expected %h", $time, g, e);
                n_errors = n_errors + 1;
            end
        end
    endtask

    task stop_test;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // One single-data-phase transfer; how: 0 data, 1 retry, 2 unclaimed
    task access(input c, input [3:0] cmd, input [31:0] a, input [31:0] d,
                input [3:0] be, input bap, input bdp);
        integer n;
        begin
            @(posedge mclk);
            frame_n <= 1'b0;
            idsel   <= c;
            ad_drv  <= a;
            cbe_n   <= cmd;
            @(posedge mclk);
            frame_n <= 1'b1;
            irdy_n  <= 1'b0;
            cbe_n   <= be;
            ad_drv  <= cmd[0] ? d : ~a;
            par_drv <= ^{a, cmd} ^ bap;
            how = 2'h2;
            for (n = 0; n < 16 && how == 2'h2; n = n + 1) begin
                // Data parity must stand one clock after the data
                @(posedge mclk);
                par_drv <= ^{d, be} ^ bdp;
                @(negedge mclk);
                got = ad_in;
                if (trdy_n === 1'b0)
                    how = 2'h0;
                else if (stop_n === 1'b0)
                    how = 2'h1;
            end
            // Data parity trails the data phase by one clock
            @(posedge mclk);
            irdy_n  <= 1'b1;
            cbe_n   <= 4'hF;
            ad_drv  <= ~ad_drv;
            par_drv <= ^{d, be} ^ bdp;
            @(posedge mclk);
            par_drv <= ~par_drv;
        end
    endtask

    task cfg(input [5:0] off, input [31:0] d, input [3:0] be, input wr);
        begin
            access(1'b1, wr ? `PCI_CMD_CFGWR : `PCI_CMD_CFGRD, {26'h0, off}, d, be, 1'b0, 1'b0);
        end
    endtask

    // Reset, retry while loading, then loaded or default fields
    task t_load(input ack, input [31:0] sub, input [23:0] lat);
        integer n;
        begin
            ack_en <= ack;
            rst    <= 1'b1;
            repeat (4) @(posedge mclk);
            rst    <= 1'b0;
            cfg(`CFG_ID_OFF, 32'h0, 4'h0, 1'b0);
            check({30'h0, how}, 32'h1);
            for (n = 0; n < 30000 && loading !== 1'b0; n = n + 1)
                @(negedge mclk);
            check({31'h0, loading}, 32'h0);
            cfg(`CFG_ID_OFF, 32'h0, 4'h0, 1'b0);
            check({30'h0, how}, 32'h0);
            cfg(`CFG_SUBSYS_OFF, 32'h0, 4'h0, 1'b0);
            check(got, sub);
            cfg(`CFG_INTR_OFF, 32'h0, 4'h0, 1'b0);
            check({8'h0, got[31:8]}, {8'h0, lat});
            check({25'h0, dev_byte[7:1]}, {25'h0, `EE_DEV_ADDR});
        end
    endtask

    // Reserved places, fixed low address bits and disabled byte lanes
    task t_cfg;
        begin
            cfg(`CFG_LAT_OFF, 32'hFFFFFFFF, 4'h0, 1'b1);
            cfg(`CFG_LAT_OFF, 32'h0, 4'h0, 1'b0);
            check(got, 32'h0000FF00);
            check({24'h0, latency}, 32'hFF);
            cfg(`CFG_BAR_OFF, 32'hFFFFFFFF, 4'h0, 1'b1);
            cfg(`CFG_BAR_OFF, 32'h0, 4'h0, 1'b0);
            check(got, 32'hFFFFFE00);
            cfg(`CFG_BAR_OFF, 32'h0, 4'h0, 1'b1);
            cfg(`CFG_BAR_OFF, 32'hFFFFFFFF, 4'h8, 1'b1);
            cfg(`CFG_BAR_OFF, 32'h0, 4'h0, 1'b0);
            check(got, 32'h00FFFE00);
        end
    endtask

    // Memory window, command bits and both parity faults
    task t_mem;
        begin
            cfg(`CFG_BAR_OFF, 32'h10000000, 4'h0, 1'b1);
            cfg(`CFG_STATCMD_OFF, 32'h00000246, 4'h0, 1'b1);
            check({30'h0, master_en, fb2b_en}, 32'h3);
            access(1'b0, `PCI_CMD_MEMRD, 32'h10000008, 32'h0, 4'h0, 1'b0, 1'b0);
            check(got, reg_rdata);
            access(1'b0, `PCI_CMD_MEMWR, 32'h20000008, 32'h1, 4'h0, 1'b0, 1'b0);
            check({30'h0, how}, 32'h2);
            access(1'b1, `PCI_CMD_CFGRD, 32'h0, 32'h0, 4'h0, 1'b1, 1'b0);
            check({30'h0, how}, 32'h2);
            pe = 1'b0;
            access(1'b1, `PCI_CMD_CFGWR, {26'h0, `CFG_INTR_OFF}, 32'h5, 4'h0, 1'b0, 1'b1);
            @(negedge mclk);
            check({31'h0, pe}, 32'h1);
        end
    endtask

    initial begin
        rst         = 1'b1;
        frame_n     = 1'b1;
        irdy_n      = 1'b1;
        idsel       = 1'b0;
        par_drv     = 1'b0;
        ack_en      = 1'b1;
        ad_drv      = 32'h0;
        cbe_n       = 4'hF;
        reg_rdata   = 32'hC0DE5A17;
        n_errors    = 0;
        comparisons = 0;
        cycles      = 0;
        t_load(1'b1, {4{8'h5A}}, {8'h5A, 8'h5A, `CFG_INTPIN});
        t_cfg;
        t_mem;
        t_load(1'b0, `CFG_SUBSYS_RST, {`CFG_MAXLAT_RST, `CFG_MINGNT_RST, `CFG_INTPIN});
        stop_test;
    end
endmodule
